/* rtl/fmi_pkg.sv */
// package of constants for the flash rewrite mode interlock
package fmi_pkg;
   localparam logic [7:0] FMI_CTRL_A_RST = 8'h01;
   localparam logic [7:0] FMI_CTRL_B_RST = 8'h00;
   localparam int FMI_READY_BIT = 0;
   localparam int FMI_REWRITE_EN_BIT = 1;
   localparam int FMI_PROT_A_BIT = 2;
   localparam int FMI_PROT_B_BIT = 1;
   localparam int FMI_EW1_BIT = 1;
   localparam int FMI_RTS_DIV = 4;
   typedef enum logic [1:0] {
      FMI_BOOT_NONE = 2'b00,
      FMI_BOOT_SERIAL = 2'b01,
      FMI_BOOT_CAN = 2'b10
   } fmi_boot_t;
endpackage

/* rtl/fmi_prot_bit.sv */
// one protected control bit with clear-then-set write interlock
`timescale 1ns/1ps
module fmi_prot_bit
   import fmi_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic force_clr,
   input wire logic wr_en,
   input wire logic wr_val,
   output logic bit_q
);
   logic bit_r;
   logic bit_nxt;
   logic armed_r;
   logic armed_nxt;

   always_comb begin
      bit_nxt = bit_r;
      armed_nxt = armed_r;
      if (force_clr) begin
         bit_nxt = 1'b0;
         armed_nxt = 1'b0;
      end else if (wr_en) begin
         if (!wr_val) begin
            bit_nxt = 1'b0;
            armed_nxt = 1'b1;
         end else begin
            if (armed_r) begin
               bit_nxt = 1'b1;
            end
            armed_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bit_r <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         bit_r <= bit_nxt;
         armed_r <= armed_nxt;
      end
   end

   assign bit_q = bit_r;

   set_needs_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && wr_val && !force_clr && !armed_r) |=> bit_r == $past(bit_r))
      else $error("protected bit set without preceding clear");

   clear_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && !wr_val) |=> !bit_r)
      else $error("zero write did not clear protected bit");
endmodule

/* rtl/fmi_interlock.sv */
// flash rewrite mode interlock: mode bits, forced reset, interrupt gating, boot pins
`timescale 1ns/1ps
module fmi_interlock
   import fmi_pkg::*;
#(
   parameter int RTS_DIV = FMI_RTS_DIV
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic nmi_pin_n,
   input wire logic wdt_irq,
   input wire logic addr_match_irq,
   input wire logic flash_busy,
   input wire logic wr_rewrite_en,
   input wire logic wr_prot_a,
   input wire logic wr_prot_b,
   input wire logic wr_val,
   input wire logic [1:0] boot_mode,
   input wire logic can_tx_user,
   output logic [7:0] flash_mode_ctrl_reg_a,
   output logic [7:0] flash_mode_ctrl_reg_b,
   output logic flash_ready_busy_flag,
   output logic ram_resident_rewrite_mode,
   output logic flash_resident_rewrite_mode,
   output logic rewrite_abort,
   output logic addr_match_grant,
   output logic can_transmit_out,
   output logic serial_request_to_send_out
);
   logic nmi_s1_r;
   logic nmi_s2_r;
   logic nmi_prev_r;
   logic nmi_req;
   logic wdt_req;
   logic force_clr;
   logic cpu_rewrite_enable_bit;
   logic protected_ctrl_bit_a;
   logic protected_ctrl_bit_b;
   logic abort_r;
   logic abort_nxt;
   logic grant_r;
   logic grant_nxt;
   logic ctx_r;
   logic ctx_nxt;
   logic rts_r;
   logic rts_nxt;
   logic [7:0] div_r;
   logic [7:0] div_nxt;
   logic [1:0] boot_s1_r;
   logic [1:0] boot_r;
   logic [2:0] wr_sel;
   logic [2:0] bits_q;

   // two-stage synchronisers for the pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nmi_s1_r <= 1'b1;
         nmi_s2_r <= 1'b1;
         nmi_prev_r <= 1'b1;
         boot_s1_r <= 2'b00;
         boot_r <= 2'b00;
      end else begin
         nmi_s1_r <= nmi_pin_n;
         nmi_s2_r <= nmi_s1_r;
         nmi_prev_r <= nmi_s2_r;
         boot_s1_r <= boot_mode;
         boot_r <= boot_s1_r;
      end
   end

   // nmi edge or ram-mode watchdog forces the mode bits
   assign nmi_req = nmi_prev_r && !nmi_s2_r;
   assign wdt_req = wdt_irq && cpu_rewrite_enable_bit && !protected_ctrl_bit_b;
   assign force_clr = nmi_req || wdt_req;

   // one interlocked cell per protected bit
   assign wr_sel = {wr_prot_b, wr_prot_a, wr_rewrite_en};

   for (genvar g = 0; g < 3; g++) begin : g_prot
      fmi_prot_bit u_bit (
         .clk(clk),
         .rst_n(rst_n),
         .force_clr(force_clr),
         .wr_en(wr_sel[g]),
         .wr_val(wr_val),
         .bit_q(bits_q[g])
      );
   end

   assign cpu_rewrite_enable_bit = bits_q[0];
   assign protected_ctrl_bit_a = bits_q[1];
   assign protected_ctrl_bit_b = bits_q[2];

   assign ram_resident_rewrite_mode = cpu_rewrite_enable_bit && !protected_ctrl_bit_b;
   assign flash_resident_rewrite_mode = cpu_rewrite_enable_bit && protected_ctrl_bit_b;
   assign flash_ready_busy_flag = !flash_busy;

   // register views of the mode bits
   always_comb begin
      flash_mode_ctrl_reg_a = FMI_CTRL_A_RST;
      flash_mode_ctrl_reg_a[FMI_READY_BIT] = !flash_busy;
      flash_mode_ctrl_reg_a[FMI_REWRITE_EN_BIT] = cpu_rewrite_enable_bit;
      flash_mode_ctrl_reg_a[FMI_PROT_A_BIT] = protected_ctrl_bit_a;
      flash_mode_ctrl_reg_b = FMI_CTRL_B_RST;
      flash_mode_ctrl_reg_b[FMI_PROT_B_BIT] = protected_ctrl_bit_b;
   end

   // abort, interrupt gating and boot pin drivers
   always_comb begin
      abort_nxt = force_clr && cpu_rewrite_enable_bit;
      grant_nxt = addr_match_irq && !ram_resident_rewrite_mode;
      div_nxt = div_r + 8'h01;
      rts_nxt = rts_r;
      ctx_nxt = can_tx_user;
      if (boot_r == FMI_BOOT_SERIAL) begin
         ctx_nxt = 1'b1;
      end
      if (boot_r == FMI_BOOT_CAN) begin
         if (div_r == 8'(RTS_DIV - 1)) begin
            div_nxt = 8'h00;
            rts_nxt = !rts_r;
         end
      end else begin
         div_nxt = 8'h00;
         rts_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         abort_r <= 1'b0;
         grant_r <= 1'b0;
         ctx_r <= 1'b1;
         rts_r <= 1'b1;
         div_r <= 8'h00;
      end else begin
         abort_r <= abort_nxt;
         grant_r <= grant_nxt;
         ctx_r <= ctx_nxt;
         rts_r <= rts_nxt;
         div_r <= div_nxt;
      end
   end

   assign rewrite_abort = abort_r;
   assign addr_match_grant = grant_r;
   assign can_transmit_out = ctx_r;
   assign serial_request_to_send_out = rts_r;

   // checks
   sequence nmi_fall_s;
      nmi_prev_r && !nmi_s2_r;
   endsequence

   sequence nmi_pin_fall_s;
      $fell(nmi_pin_n);
   endsequence

   sequence can_boot_run_s;
      (boot_r == FMI_BOOT_CAN) [*8];
   endsequence

   nmi_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
      nmi_fall_s |=> !cpu_rewrite_enable_bit && !protected_ctrl_bit_a && !protected_ctrl_bit_b)
      else $error("nmi did not reset mode registers");

   nmi_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
      nmi_pin_fall_s |-> ##3 !cpu_rewrite_enable_bit)
      else $error("nmi pin fall did not clear rewrite enable in time");

   nmi_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
      (nmi_fall_s ##0 cpu_rewrite_enable_bit) |=> rewrite_abort)
      else $error("nmi did not abort rewrite");

   abort_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      rewrite_abort |=> !rewrite_abort)
      else $error("abort pulse longer than one cycle");

   wdt_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wdt_irq && ram_resident_rewrite_mode) |=> !cpu_rewrite_enable_bit ##0 rewrite_abort)
      else $error("watchdog did not abort ram mode rewrite");

   addr_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      ram_resident_rewrite_mode |=> !addr_match_grant)
      else $error("address match granted in ram mode");

   grant_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      !ram_resident_rewrite_mode |=> addr_match_grant == $past(addr_match_irq))
      else $error("address match grant does not follow request");

   ctx_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      (boot_r == FMI_BOOT_SERIAL) |=> can_transmit_out)
      else $error("can transmit not high in serial boot");

   ctx_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      (boot_r != FMI_BOOT_SERIAL) |=> can_transmit_out == $past(can_tx_user))
      else $error("can transmit does not follow user value");

   rts_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (boot_r != FMI_BOOT_CAN) |=> serial_request_to_send_out)
      else $error("rts not high outside can boot");

   rts_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      can_boot_run_s |-> rts_r != $past(rts_r, RTS_DIV))
      else $error("rts stuck in can boot");

endmodule

/* tb/fmi_sw_model.sv */
// partner model: rewrite program writing the mode bits
`timescale 1ns/1ps
module fmi_sw_model (
   input wire logic clk,
   output logic wr_rewrite_en,
   output logic wr_prot_a,
   output logic wr_prot_b,
   output logic wr_val
);
   initial begin
      {wr_rewrite_en, wr_prot_a, wr_prot_b, wr_val} = 4'h0;
   end
   // one strobe, data inverted once released
   task automatic wr(input logic [1:0] sel, input logic v);
      @(negedge clk);
      wr_rewrite_en = (sel == 2'h0);
      wr_prot_a = (sel == 2'h1);
      wr_prot_b = (sel == 2'h2);
      wr_val = v;
      @(negedge clk);
      {wr_rewrite_en, wr_prot_a, wr_prot_b} = 3'h0;
      wr_val = ~v;
   endtask
   // clear (only if arm) then set, nothing in between
   task automatic set_bit(input logic [1:0] sel, input logic arm);
      if (arm) begin
         wr(sel, 1'b0);
      end
      wr(sel, 1'b1);
   endtask
endmodule

/* tb/tb_top.sv */
// testbench for the flash rewrite mode interlock
`timescale 1ns/1ps
module tb_top;
   import fmi_pkg::*;
   logic clk = 0, rst_n = 0, nmi_pin_n = 1, wdt_irq = 0, am_irq = 0, busy = 0, ctu = 0;
   logic [1:0] boot = FMI_BOOT_SERIAL;
   logic wre, wpa, wpb, wv, rdy, ram_m, fl_m, abort, grant, ctx, rts, last;
   logic [7:0] ra, rb;
   int n_fail = 0, n_checks = 0, tog = 0;
   initial begin
      forever #12.5 clk = ~clk;
   end
   fmi_sw_model sw (.clk(clk), .wr_rewrite_en(wre), .wr_prot_a(wpa), .wr_prot_b(wpb),
      .wr_val(wv));
   fmi_interlock #(.RTS_DIV(FMI_RTS_DIV)) DUT (.clk(clk), .rst_n(rst_n), .nmi_pin_n(nmi_pin_n),
      .wdt_irq(wdt_irq), .addr_match_irq(am_irq), .flash_busy(busy), .wr_rewrite_en(wre),
      .wr_prot_a(wpa), .wr_prot_b(wpb), .wr_val(wv), .boot_mode(boot), .can_tx_user(ctu),
      .flash_mode_ctrl_reg_a(ra), .flash_mode_ctrl_reg_b(rb), .flash_ready_busy_flag(rdy),
      .ram_resident_rewrite_mode(ram_m), .flash_resident_rewrite_mode(fl_m),
      .rewrite_abort(abort), .addr_match_grant(grant), .can_transmit_out(ctx),
      .serial_request_to_send_out(rts));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task reset_to(input logic [1:0] b);
      boot = b;
      rst_n = 0;
      cyc(8);
      rst_n = 1;
   endtask
   task wait_abort;
      for (int i = 0; i < 8 && abort !== 1'b1; i++) cyc(1);
      if (abort !== 1'b1) begin
         n_fail++;
         close_out;
      end
   endtask
   task t_reset_serial;
      reset_to(FMI_BOOT_SERIAL);
      chk(ra, FMI_CTRL_A_RST);
      chk(rb, FMI_CTRL_B_RST);
      cyc(3);
      chk(ctx, 1'b1);
      ctu = 1;
      cyc(1);
      ctu = 0;
      cyc(1);
      chk(ctx, 1'b1);
      chk(rts, 1'b1);
      $display("reset and serial boot done");
   endtask
   task t_protected;
      sw.set_bit(2'h0, 1'b0);
      chk(ra[FMI_REWRITE_EN_BIT], 1'b0);
      sw.set_bit(2'h0, 1'b1);
      chk(ram_m, 1'b1);
      chk(fl_m, 1'b0);
      am_irq = 1;
      cyc(2);
      chk(grant, 1'b0);
      sw.set_bit(2'h1, 1'b1);
      chk(ra[FMI_PROT_A_BIT], 1'b1);
      sw.set_bit(2'h2, 1'b1);
      chk(fl_m, 1'b1);
      cyc(2);
      chk(grant, 1'b1);
      am_irq = 0;
      busy = 1;
      cyc(1);
      chk(rdy, 1'b0);
      chk(ra[FMI_READY_BIT], 1'b0);
      busy = 0;
      $display("protected writes done");
   endtask
   task t_forced;
      wdt_irq = 1;
      cyc(3);
      wdt_irq = 0;
      chk(rb[FMI_PROT_B_BIT], 1'b1);
      nmi_pin_n = 0;
      wait_abort;
      chk(ra, FMI_CTRL_A_RST);
      chk(rb, FMI_CTRL_B_RST);
      cyc(1);
      chk(abort, 1'b0);
      nmi_pin_n = 1;
      cyc(4);
      sw.set_bit(2'h0, 1'b1);
      chk(ram_m, 1'b1);
      wdt_irq = 1;
      wait_abort;
      wdt_irq = 0;
      chk(ra, FMI_CTRL_A_RST);
      $display("forced reset done");
   endtask
   task t_can_boot;
      reset_to(FMI_BOOT_CAN);
      cyc(8);
      last = rts;
      for (int k = 0; k < 16; k++) begin
         cyc(1);
         if (rts !== last) tog++;
         last = rts;
      end
      chk(8'(tog), 8'(16 / FMI_RTS_DIV));
      ctu = 1;
      cyc(1);
      chk(ctx, 1'b1);
      ctu = 0;
      cyc(1);
      chk(ctx, 1'b0);
      $display("can boot done");
   endtask
   initial begin
      t_reset_serial;
      t_protected;
      t_forced;
      t_can_boot;
      close_out;
   end
endmodule
